// ### logic/emp_power_ctrl.sv
// Purpose: Energy mode sequencer driving domain switches and core voltage level
// Assumes: One core clock; software writes modes over Avalon-MM
// Notes:   Notes on behaviour are listed below
//
// Notes on behaviour
// - Always-on domain stays powered in every mode, shutoff included.
// - Shutoff mode powers down all low-power group domains.
// - Base retention domain powered in run, sleep, deep-sleep and stop.
// - In deep-sleep or stop, aux domain powered if a hosted peripheral enabled.
// - Aux domain powered down when none of its peripherals is enabled.
// - Shared aux domain on whenever aux b, c or d is in use.
// - Active domain always powered in run and sleep.
// - Active domain powered down in deep-sleep, stop and shutoff.
// - Unlisted peripherals live on the active domain.
// - Two level selections: one for run/sleep, one for deep-sleep/stop.
// - Run/sleep level resets to the highest level.
// - Lowest level selectable for deep-sleep and stop.
// - Mode transitions switch target level automatically.
// - Software may power down unused RAM blocks.
// - Low-supply monitor event raises an interrupt for bypass.
// - Soft switching at boot and on regulate-to-bypass moves.
//
// The implementer's own choices: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/100ps

module emp_power_ctrl #(
    parameter int RAM_BLOCKS = 8
) (
    // Clock and reset
    input  wire logic                        core_clk,
    input  wire logic                        rst_n,
    // Avalon-MM slave
    input  wire logic [5:0]                  avs_address,
    input  wire logic                        avs_read,
    input  wire logic                        avs_write,
    input  wire logic [31:0]                 avs_writedata,
    input  wire logic [3:0]                  avs_byteenable,
    output logic      [31:0]                 avs_readdata,
    output logic                             avs_waitrequest,
    output logic      [1:0]                  avs_response,
    // Peripheral enables of aux domains b, c, d
    input  wire logic [2:0]                  auxPeriphEn,
    // Wake event and supply monitor, from pins
    input  wire logic                        wakeRequest,
    input  wire logic                        lowSupplyPin,
    // Power switches and regulator
    output emp_pkg::emp_domains_type         domainPower,
    output emp_pkg::emp_level_type           voltageTarget,
    output logic      [RAM_BLOCKS-1:0]       ramPower,
    output logic                             buckBypass,
    output logic      [2:0]                  softStep,
    output logic                             coreRelease,
    output logic                             irq
);
    import emp_pkg::*;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    emp_mode_type                mode_reg;
    emp_level_type               runLevel_reg;
    emp_level_type               lowLevel_reg;
    logic [RAM_BLOCKS-1:0]       ram_reg;
    logic [2:0]                  auxEnReg;
    logic [EMP_IRQ_WIDTH-1:0]    irqStat_reg;
    logic [EMP_IRQ_WIDTH-1:0]    irqMask_reg;
    logic                        bypassReq_reg;
    emp_state_type               state_reg;
    logic [15:0]                 timer_reg;
    logic [2:0]                  step_reg;
    logic                        bypass_reg;
    logic                        booted_reg;
    logic                        readPend_reg;
    logic [31:0]                 rdata_reg;
    logic [1:0]                  wakeSync_reg;
    logic [1:0]                  lowSync_reg;
    logic                        lowPrev_reg;

    logic wakeSeen;
    logic lowRise;
    logic wrCtrl;
    logic wrPeriph;
    logic wrRam;
    logic wrMask;
    logic wrBuck;
    logic rdIrq;
    logic mapped;
    logic bypassDone;
    logic [31:0] rdMux;
    logic [EMP_IRQ_WIDTH-1:0] irqSet;
    logic lowModeReq;

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    // Pins come from outside the clock domain
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            wakeSync_reg <= 2'h0;
            lowSync_reg  <= 2'h0;
            lowPrev_reg  <= 1'b0;
        end else begin
            wakeSync_reg <= {wakeSync_reg[0], wakeRequest};
            lowSync_reg  <= {lowSync_reg[0], lowSupplyPin};
            lowPrev_reg  <= lowSync_reg[1];
        end
    end

    assign wakeSeen = wakeSync_reg[1];
    assign lowRise  = lowSync_reg[1] & ~lowPrev_reg;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    // Writes complete in the request cycle; reads take one wait cycle
    always_comb begin
        mapped = 1'b1;
        if (avs_address == EMP_CTRL_OFFSET) begin
            rdMux = {20'h0, 2'h0, lowLevel_reg, 2'h0, runLevel_reg, 1'b0, mode_reg};
        end else if (avs_address == EMP_STATUS_OFFSET) begin
            rdMux = {16'h0, booted_reg, bypass_reg, coreRelease, state_reg,
                     1'b0, domainPower};
        end else if (avs_address == EMP_PERIPH_OFFSET) begin
            rdMux = 32'h0;
            rdMux[2:0] = auxEnReg;
        end else if (avs_address == EMP_RAM_OFFSET) begin
            rdMux = 32'h0;
            rdMux[RAM_BLOCKS-1:0] = ram_reg;
        end else if (avs_address == EMP_IRQ_OFFSET) begin
            rdMux = {29'h0, irqStat_reg};
        end else if (avs_address == EMP_MASK_OFFSET) begin
            rdMux = {29'h0, irqMask_reg};
        end else if (avs_address == EMP_BUCK_OFFSET) begin
            rdMux = {31'h0, bypassReq_reg};
        end else begin
            rdMux  = 32'h0;
            mapped = 1'b0;
        end
    end

    assign wrCtrl   = avs_write && avs_byteenable[0] && avs_address == EMP_CTRL_OFFSET;
    assign wrPeriph = avs_write && avs_byteenable[0] && avs_address == EMP_PERIPH_OFFSET;
    assign wrRam    = avs_write && avs_byteenable[0] && avs_address == EMP_RAM_OFFSET;
    assign wrMask   = avs_write && avs_byteenable[0] && avs_address == EMP_MASK_OFFSET;
    assign wrBuck   = avs_write && avs_byteenable[0] && avs_address == EMP_BUCK_OFFSET;
    assign rdIrq    = avs_read && readPend_reg && avs_address == EMP_IRQ_OFFSET;

    assign avs_waitrequest = avs_read && !readPend_reg;

    // Read data captured one cycle after the request
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            readPend_reg <= 1'b0;
            rdata_reg    <= 32'h0;
            avs_response <= 2'h0;
        end else begin
            readPend_reg <= avs_read && !readPend_reg;
            if (avs_read && !readPend_reg) begin
                rdata_reg    <= rdMux;
                avs_response <= mapped ? 2'h0 : 2'h2;
            end else if (avs_write) begin
                avs_response <= mapped ? 2'h0 : 2'h2;
            end
        end
    end

    assign avs_readdata = rdata_reg;

    // ------------------------------------------------------------
    // Software configuration
    // ------------------------------------------------------------
    // Modes and levels; reserved level code falls back to high
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            mode_reg     <= EMP_RUN_MODE;
            runLevel_reg <= EMP_VOLTAGE_LEVEL_HIGH;
            lowLevel_reg <= EMP_VOLTAGE_LEVEL_LOW;
        end else begin
            if (wrCtrl) begin
                if (avs_writedata[2:0] <= 3'h4) begin
                    mode_reg <= emp_mode_type'(avs_writedata[2:0]);
                end
                // Separate run and low-mode selections
                runLevel_reg <= (avs_writedata[5:4] == 2'h3) ? EMP_VOLTAGE_LEVEL_HIGH
                                : emp_level_type'(avs_writedata[5:4]);
                lowLevel_reg <= (avs_writedata[9:8] == 2'h3) ? EMP_VOLTAGE_LEVEL_HIGH
                                : emp_level_type'(avs_writedata[9:8]);
            end else if (state_reg == EMP_ST_WAKE && timer_reg == 16'h0) begin
                // Wake returns software to run mode
                mode_reg <= EMP_RUN_MODE;
            end
        end
    end

    // Peripheral enables are the OR of pin enables and register enables
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            auxEnReg <= 3'h0;
            ram_reg  <= '1;
            irqMask_reg   <= '0;
            bypassReq_reg <= 1'b0;
        end else begin
            if (wrPeriph) begin
                auxEnReg <= avs_writedata[2:0];
            end
            if (wrRam) begin
                ram_reg <= avs_writedata[RAM_BLOCKS-1:0];
            end
            if (wrMask) begin
                irqMask_reg <= avs_writedata[EMP_IRQ_WIDTH-1:0];
            end
            if (wrBuck) begin
                bypassReq_reg <= avs_writedata[0];
            end
        end
    end

    assign ramPower = ram_reg;

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    assign lowModeReq = mode_reg != EMP_RUN_MODE && mode_reg != EMP_SLEEP_MODE;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_reg <= EMP_ST_RUN;
            timer_reg <= 16'(EMP_SETTLE_CYC);
        end else begin
            case (state_reg)
                EMP_ST_RUN: begin
                    if (lowModeReq && booted_reg) begin
                        state_reg <= EMP_ST_ENTER;
                        timer_reg <= 16'(EMP_SETTLE_CYC);
                    end
                end
                EMP_ST_ENTER: begin
                    if (timer_reg != 16'h0) begin
                        timer_reg <= timer_reg - 16'h1;
                    end else begin
                        state_reg <= EMP_ST_LOW;
                    end
                end
                EMP_ST_LOW: begin
                    // Shutoff leaves only through reset
                    if (wakeSeen && mode_reg != EMP_SHUTOFF_MODE) begin
                        state_reg <= EMP_ST_RAMP;
                        timer_reg <= 16'(EMP_SETTLE_CYC);
                    end
                end
                EMP_ST_RAMP: begin
                    // Run level settles first, then the active domain
                    if (timer_reg != 16'h0) begin
                        timer_reg <= timer_reg - 16'h1;
                    end else begin
                        state_reg <= EMP_ST_WAKE;
                        timer_reg <= 16'(EMP_SETTLE_CYC);
                    end
                end
                EMP_ST_WAKE: begin
                    if (timer_reg != 16'h0) begin
                        timer_reg <= timer_reg - 16'h1;
                    end else begin
                        state_reg <= EMP_ST_RUN;
                    end
                end
                default: begin
                    state_reg <= EMP_ST_RUN;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Domain and level outputs
    // ------------------------------------------------------------
    // Registered so switches never glitch on bus writes
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            domainPower   <= '{alwaysOn: 1'b1, baseRetention: 1'b1, active: 1'b1,
                               default: 1'b0};
            voltageTarget <= EMP_VOLTAGE_LEVEL_HIGH;
            coreRelease   <= 1'b0;
        end else begin
            domainPower.alwaysOn <= 1'b1;
            if (state_reg == EMP_ST_LOW && mode_reg == EMP_SHUTOFF_MODE) begin
                domainPower.baseRetention <= 1'b0;
                domainPower.auxB          <= 1'b0;
                domainPower.auxC          <= 1'b0;
                domainPower.auxD          <= 1'b0;
                domainPower.sharedAux     <= 1'b0;
            end else begin
                domainPower.baseRetention <= 1'b1;
                // Aux domains follow their peripheral enables
                domainPower.auxB      <= auxEnReg[0] | auxPeriphEn[0];
                domainPower.auxC      <= auxEnReg[1] | auxPeriphEn[1];
                domainPower.auxD      <= auxEnReg[2] | auxPeriphEn[2];
                domainPower.sharedAux <= |(auxEnReg | auxPeriphEn);
            end
            // Unlisted peripherals share the active switch
            domainPower.active <= state_reg == EMP_ST_RUN ||
                                  state_reg == EMP_ST_WAKE;
            // Level follows the mode without software action
            if (state_reg == EMP_ST_LOW) begin
                voltageTarget <= lowLevel_reg;
            end else begin
                voltageTarget <= runLevel_reg;
            end
            coreRelease <= state_reg == EMP_ST_RUN && booted_reg;
        end
    end

    // ------------------------------------------------------------
    // Buck soft switching
    // ------------------------------------------------------------
    // Steps the drive strength up at boot and down before bypass, one step per cycle; leaving bypass restores step 7 at once
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            step_reg   <= 3'h0;
            bypass_reg <= 1'b0;
            booted_reg <= 1'b0;
        end else begin
            if (!booted_reg) begin
                step_reg <= step_reg + 3'h1;
                if (step_reg == 3'(EMP_SOFT_STEPS - 1)) begin
                    booted_reg <= 1'b1;
                end
            end else if (bypassReq_reg && !bypass_reg) begin
                step_reg <= step_reg - 3'h1;
                if (step_reg == 3'h1) begin
                    bypass_reg <= 1'b1;
                end
            end else if (!bypassReq_reg && bypass_reg) begin
                bypass_reg <= 1'b0;
                step_reg   <= 3'h7;
            end
        end
    end

    assign softStep   = step_reg;
    assign buckBypass = bypass_reg;
    assign bypassDone = bypassReq_reg && !bypass_reg && step_reg == 3'h1 && booted_reg;

    // ------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------
    assign irqSet = {bypassDone, state_reg == EMP_ST_WAKE && timer_reg == 16'h0, lowRise};

    // Set wins; a read clears only the bits it returned, so no event is lost
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            irqStat_reg <= '0;
        end else begin
            irqStat_reg <= (irqStat_reg & ~(rdIrq ? rdata_reg[EMP_IRQ_WIDTH-1:0] : '0))
                           | irqSet;
        end
    end

    assign irq = |(irqStat_reg & irqMask_reg);

endmodule

// ### logic/emp_pkg.sv
// Purpose: Shared constants and types for the energy mode power domain controller
// Assumes: 100 MHz core clock, 32-bit Avalon-MM register bus
// Notes:   Offsets are byte addresses of aligned words
package emp_pkg;

    // ------------------------------------------------------------
    // Energy modes and voltage levels
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        EMP_RUN_MODE        = 3'h0,
        EMP_SLEEP_MODE      = 3'h1,
        EMP_DEEP_SLEEP_MODE = 3'h2,
        EMP_STOP_MODE       = 3'h3,
        EMP_SHUTOFF_MODE    = 3'h4
    } emp_mode_type;

    typedef enum logic [1:0] {
        EMP_VOLTAGE_LEVEL_LOW  = 2'h0,
        EMP_VOLTAGE_LEVEL_MID  = 2'h1,
        EMP_VOLTAGE_LEVEL_HIGH = 2'h2
    } emp_level_type;

    // Sequencer states, one-hot
    typedef enum logic [4:0] {
        EMP_ST_RUN     = 5'h01,
        EMP_ST_ENTER   = 5'h02,
        EMP_ST_LOW     = 5'h04,
        EMP_ST_RAMP    = 5'h08,
        EMP_ST_WAKE    = 5'h10
    } emp_state_type;

    // ------------------------------------------------------------
    // Domain switch bundle
    // ------------------------------------------------------------
    typedef struct packed {
        logic alwaysOn;
        logic baseRetention;
        logic auxB;
        logic auxC;
        logic auxD;
        logic sharedAux;
        logic active;
    } emp_domains_type;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [5:0] EMP_CTRL_OFFSET    = 6'h00;
    localparam logic [5:0] EMP_STATUS_OFFSET  = 6'h04;
    localparam logic [5:0] EMP_PERIPH_OFFSET  = 6'h08;
    localparam logic [5:0] EMP_RAM_OFFSET     = 6'h0c;
    localparam logic [5:0] EMP_IRQ_OFFSET     = 6'h10;
    localparam logic [5:0] EMP_MASK_OFFSET    = 6'h14;
    localparam logic [5:0] EMP_BUCK_OFFSET    = 6'h18;

    // CTRL fields
    localparam int EMP_CTRL_MODE_LSB    = 0;
    localparam int EMP_CTRL_RUNLVL_LSB  = 4;
    localparam int EMP_CTRL_LOWLVL_LSB  = 8;
    // IRQ bits
    localparam int EMP_IRQ_LOWSUPPLY    = 0;
    localparam int EMP_IRQ_WAKE         = 1;
    localparam int EMP_IRQ_BYPASSDONE   = 2;
    localparam int EMP_IRQ_WIDTH        = 3;

    // Reset values
    localparam logic [1:0] EMP_RUNLVL_RESET = 2'h2;
    localparam logic [1:0] EMP_LOWLVL_RESET = 2'h0;
    localparam logic [1:0] EMP_SOFT_STEP_RESET = 2'h0;

    // Timing
    localparam int EMP_CLK_MHZ          = 100;
    localparam int EMP_SETTLE_NS        = 500;
    localparam int EMP_SETTLE_CYC       = (EMP_SETTLE_NS * EMP_CLK_MHZ + 999) / 1000;
    localparam int EMP_SOFT_STEP_NS     = 200;
    localparam int EMP_SOFT_STEP_CYC    = (EMP_SOFT_STEP_NS * EMP_CLK_MHZ + 999) / 1000;
    localparam int EMP_SOFT_STEPS       = 8;

endpackage

// ### verification/emp_power_ctrl_props.sv
// Purpose: Port-level checks for the energy mode controller
// Assumes: One core clock, synchronous active-low reset
// Notes:   Bound into every controller below
`timescale 1ns/100ps

module emp_power_ctrl_props #(
    parameter int RAM_BLOCKS = 8
) (
    // Clock and reset
    input wire logic                     core_clk,
    input wire logic                     rst_n,
    // Register bus
    input wire logic [5:0]               avs_address,
    input wire logic                     avs_read,
    input wire logic [31:0]              avs_readdata,
    input wire logic                     avs_waitrequest,
    input wire logic [1:0]               avs_response,
    // Power outputs
    input wire emp_pkg::emp_domains_type domainPower,
    input wire logic [RAM_BLOCKS-1:0]    ramPower,
    input wire logic [2:0]               softStep,
    input wire logic                     coreRelease
);
    import emp_pkg::*;

    // ----------
    // Helpers
    // ----------
    // Any private aux domain
    wire logic auxAny = domainPower.auxB || domainPower.auxC || domainPower.auxD;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    // ----------
    // Checks
    // ----------
    chk_always_on: assert property (domainPower.alwaysOn)
        else $error("always-on domain dropped");
    chk_group_off: assert property (!domainPower.baseRetention |->
        !(auxAny || domainPower.sharedAux || domainPower.active))
        else $error("group on without base domain");
    chk_shared_aux: assert property (auxAny |-> domainPower.sharedAux)
        else $error("shared aux off");
    chk_core_active: assert property (coreRelease |-> domainPower.active)
        else $error("core released, active off");
    chk_wake_release: assert property ($rose(domainPower.active) |->
        ##[1:120] coreRelease)
        else $error("core not released after wake");
    chk_boot_release: assert property ($rose(rst_n) |->
        !coreRelease [*8] ##[1:6] coreRelease)
        else $error("boot soft start wrong");
    chk_soft_step: assert property ($changed(softStep) |->
        (3'(softStep - $past(softStep)) inside {3'h1, 3'h7}))
        else $error("soft switch jumped");
    chk_ram_reset: assert property ($rose(rst_n) |-> &ramPower)
        else $error("RAM not all powered after reset");
    chk_read_wait: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("read wait cycle wrong");
    chk_unmapped_rd: assert property (avs_read && !avs_waitrequest && avs_address > 6'h18
        |-> avs_response == 2'h2 && avs_readdata == 32'h0)
        else $error("unmapped read not refused");
endmodule

bind emp_power_ctrl emp_power_ctrl_props #(.RAM_BLOCKS(RAM_BLOCKS)) emp_power_ctrl_props_inst (
    .core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .avs_response(avs_response), .domainPower(domainPower), .ramPower(ramPower),
    .softStep(softStep), .coreRelease(coreRelease));

// ### verification/emp_supply_model.sv
// Purpose: Behavioural supply monitor beside the buck regulator
// Assumes: Bench commands a droop by dropCmd
// Notes:   Bypass restores the supply, so the low flag then clears
`timescale 1ns/100ps

module emp_supply_model (
    // Clock
    input wire logic  core_clk,
    // Bench control and regulator state
    input wire logic  dropCmd,
    input wire logic  buckBypass,
    // Monitor output
    output logic      lowSupplyPin = 1'b0
);
    // ----------
    // Monitor
    // ----------
    // Registered, like a slow comparator
    always @(posedge core_clk) begin
        lowSupplyPin <= dropCmd && !buckBypass;
    end
endmodule

// ### verification/tb.sv
// Purpose: Self-checking bench for the energy mode power domain controller
// Assumes: 100 MHz core_clk
// Notes:   Random stimulus from a fixed seed
`timescale 1ns/100ps

module tb;
    import emp_pkg::*;

    // ----------
    // Signals
    // ----------
    logic            core_clk = 1'b0;
    logic            rst_n = 1'b0;
    logic [5:0]      avs_address = 6'h00;
    logic            avs_read = 1'b0;
    logic            avs_write = 1'b0;
    logic [31:0]     avs_writedata = 32'h0;
    logic [31:0]     avs_readdata;
    logic            avs_waitrequest;
    logic [1:0]      avs_response;
    logic [2:0]      auxPeriphEn = 3'h0;
    logic            wakeRequest = 1'b0;
    logic            dropCmd = 1'b0;
    logic            lowSupplyPin;
    emp_domains_type domainPower;
    emp_level_type   voltageTarget;
    logic [7:0]      ramPower;
    logic            buckBypass;
    logic [2:0]      softStep;
    logic            coreRelease;
    logic            irq;
    logic [31:0]     rdData;
    logic [1:0]      rdResp;
    int              n_errors = 0;
    int              compares = 0;
    int              cycles = 0;
    int              seed = 32'h667b60b9;

    // 100 MHz clock
    initial begin
        forever #5 core_clk = ~core_clk;
    end

    emp_power_ctrl #(.RAM_BLOCKS(8)) emp_power_ctrl_inst (
        .core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
        .auxPeriphEn(auxPeriphEn), .wakeRequest(wakeRequest), .lowSupplyPin(lowSupplyPin),
        .domainPower(domainPower), .voltageTarget(voltageTarget), .ramPower(ramPower),
        .buckBypass(buckBypass), .softStep(softStep), .coreRelease(coreRelease), .irq(irq));

    emp_supply_model emp_supply_model_inst (
        .core_clk(core_clk), .dropCmd(dropCmd), .buckBypass(buckBypass),
        .lowSupplyPin(lowSupplyPin));

    // ----------
    // Helpers
    // ----------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Expected switches
    function automatic emp_domains_type expDom(input logic [2:0] en, input logic act);
        expDom = '{1'b1, 1'b1, en[0], en[1], en[2], |en, act};
    endfunction

    task automatic chkDom(input logic [2:0] en, input logic act);
        check(32'(domainPower), 32'(expDom(en, act)));
    endtask

    task automatic settle(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    // Request stands until waitrequest is sampled low at a rising edge
    task automatic bus(input logic wr, input logic [5:0] addr, input logic [31:0] data);
        @(posedge core_clk);
        avs_write     <= wr;
        avs_read      <= !wr;
        avs_address   <= addr;
        avs_writedata <= data;
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        rdData = avs_readdata;
        rdResp = avs_response;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask

    task automatic print_verdict();
        $display("compares=%0d n_errors=%0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Hang guard
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            print_verdict();
        end
    end

    // ----------
    // Sequence
    // ----------
    initial begin
        logic [2:0] en;
        logic [7:0] ram;
        logic       lvl;
        int         k;
        int         j;
        en = 3'h0;
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
        @(negedge core_clk);
        chkDom(3'h0, 1'b1);
        check(32'(voltageTarget), 32'h2);
        check(32'(ramPower), 32'hff);
        for (j = 0; j < 40 && coreRelease !== 1'b1; j++) @(negedge core_clk);
        check(32'(coreRelease), 32'h1);
        bus(1'b0, EMP_STATUS_OFFSET, 32'h0);
        check(rdData, 32'ha161);
        bus(1'b0, EMP_CTRL_OFFSET, 32'h0);
        check(rdData, 32'h20);
        bus(1'b0, 6'h3c, 32'h0);
        check(32'(rdResp), 32'h2);
        $display("test reset done");
        // Corners all-off and all-on, then random enables
        for (k = 0; k < 8; k++) begin
            en = (k < 2) ? {3{k[0]}} : 3'($random(seed));
            @(posedge core_clk);
            auxPeriphEn <= en;
            settle(4);
            chkDom(en, 1'b1);
        end
        ram = 8'($random(seed));
        bus(1'b1, EMP_RAM_OFFSET, {24'h0, ram});
        settle(2);
        check(32'(ramPower), {24'h0, ram});
        bus(1'b0, EMP_RAM_OFFSET, 32'h0);
        check(rdData, {24'h0, ram});
        $display("test aux and ram done");
        // Deep-sleep then stop, each woken by the pin
        for (k = 2; k < 4; k++) begin
            lvl = 1'($random(seed));
            bus(1'b1, EMP_CTRL_OFFSET, {23'h0, lvl, 8'h20} | 32'(k));
            for (j = 0; j < 200 && domainPower.active !== 1'b0; j++) @(negedge core_clk);
            settle(55);
            check(32'(voltageTarget), {31'h0, lvl});
            chkDom(en, 1'b0);
            check(32'(coreRelease), 32'h0);
            @(posedge core_clk);
            wakeRequest <= 1'b1;
            for (j = 0; j < 400 && coreRelease !== 1'b1; j++) @(negedge core_clk);
            check(32'(voltageTarget), 32'h2);
            chkDom(en, 1'b1);
            @(posedge core_clk);
            wakeRequest <= 1'b0;
            bus(1'b0, EMP_CTRL_OFFSET, 32'h0);
            check(rdData, {23'h0, lvl, 8'h20});
            bus(1'b0, EMP_IRQ_OFFSET, 32'h0);
            check(rdData & 32'h2, 32'h2);
        end
        $display("test low modes done");
        // Low supply held masked, then unmasked, cleared and bypassed
        bus(1'b1, EMP_MASK_OFFSET, 32'h0);
        @(posedge core_clk);
        dropCmd <= 1'b1;
        settle(6);
        check(32'(irq), 32'h0);
        bus(1'b1, EMP_MASK_OFFSET, 32'h1);
        settle(2);
        check(32'(irq), 32'h1);
        bus(1'b0, EMP_IRQ_OFFSET, 32'h0);
        check(rdData & 32'h1, 32'h1);
        settle(2);
        check(32'(irq), 32'h0);
        bus(1'b1, EMP_BUCK_OFFSET, 32'h1);
        for (j = 0; j < 100 && buckBypass !== 1'b1; j++) @(negedge core_clk);
        check(32'(buckBypass), 32'h1);
        $display("test supply done");
        bus(1'b1, EMP_CTRL_OFFSET, 32'h24);
        for (j = 0; j < 200 && domainPower.baseRetention !== 1'b0; j++) @(negedge core_clk);
        settle(2);
        check(32'(domainPower), 32'h40);
        check(32'(coreRelease), 32'h0);
        $display("test shutoff done");
        print_verdict();
    end
endmodule
